/* File: design/stp_cfg.svh */
// offsets, field positions, reset values and counts of the shared timer prescaler
`ifndef STP_CFG_SVH
`define STP_CFG_SVH
// register offsets (byte addresses on the plain register port)
`define STP_OFS_SYNC_CTRL 4'h0
`define STP_OFS_CLK_SEL 4'h1
`define STP_OFS_COUNT 4'h2
`define STP_OFS_CMP_A 4'h3
`define STP_OFS_CMP_B 4'h4
`define STP_OFS_FLAGS 4'h5
`define STP_OFS_MASK 4'h6
`define STP_OFS_CTRL 4'h7
// timer_sync_control fields
`define STP_BIT_HOLD 7
`define STP_BIT_CAPSEL 6
`define STP_BIT_PSR 0
// clk_sel fields: timer 0 in [2:0], timer 1 in [6:4]
`define STP_CS0_LSB 0
`define STP_CS1_LSB 4
// flag / mask fields
`define STP_BIT_OVF 0
`define STP_BIT_CMPA 1
`define STP_BIT_CMPB 2
// ctrl fields: power off, top from compare a
`define STP_BIT_PWR_OFF 0
`define STP_BIT_TOP_A 1
// reset values
`define STP_RST_SYNC_CTRL 8'h00
`define STP_RST_CTRL 8'h01
// clock source codes
`define STP_CS_STOP 3'h0
`define STP_CS_DIRECT 3'h1
`define STP_CS_DIV8 3'h2
`define STP_CS_DIV64 3'h3
`define STP_CS_DIV256 3'h4
`define STP_CS_DIV1024 3'h5
`define STP_CS_FALL 3'h6
`define STP_CS_RISE 3'h7
// counter limits
`define STP_BOTTOM 8'h00
`define STP_MAX 8'hff
`endif

/* File: design/stp_pkg.sv */
// types of the shared timer prescaler block
package stp_pkg;
   // register port request
   typedef struct packed {
      logic [3:0] addr;
      logic [7:0] wdata;
      logic wr;
      logic rd;
   } stp_req_t;
   // whole state of the block
   typedef struct packed {
      logic [9:0] presc;
      logic hold;
      logic capsel;
      logic psr;
      logic [2:0] cs0;
      logic [2:0] cs1;
      logic [7:0] count;
      logic [7:0] cmp_a;
      logic [7:0] cmp_b;
      logic [2:0] flags;
      logic [2:0] mask;
      logic pwr_off;
      logic top_a;
      logic [1:0] ext_sync;
      logic ext_prev;
      logic block_cmp;
      logic [7:0] rdata;
   } stp_state_t;
endpackage

/* File: design/stp_timer_prescaler.sv */
// shared prescaler and clock select for two timers, with the 8-bit counter of timer 0
`timescale 1ns/1ps
`include "stp_cfg.svh"

module stp_timer_prescaler (
   input wire logic clock,
   input wire logic rst_n,
   input wire logic [3:0] addr,
   input wire logic [7:0] wdata,
   input wire logic wr,
   input wire logic rd,
   output logic [7:0] rdata,
   input wire logic external_count_pin,
   input wire logic capture_input_a,
   input wire logic capture_input_b,
   output logic timer_tick0,
   output logic timer_tick1,
   output logic capture_trigger1,
   output logic timer_irq
);

   ////////////////////////////////////////////////////////////////////////////
   // state and request carrier

   stp_pkg::stp_state_t state; // registered state
   stp_pkg::stp_state_t next_state; // computed next state
   stp_pkg::stp_req_t req; // bundled register request
   logic pin_latch; // transparent while clock is high
   logic [3:0] tap; // divided taps: /8 /64 /256 /1024
   logic psr_active; // prescaler held or cleared this cycle
   logic ext_rise; // rising edge seen on synced pin
   logic ext_fall; // falling edge seen on synced pin
   logic tick0; // timer 0 tick
   logic tick1; // timer 1 tick
   logic wr_count; // processor writes the counter
   logic [7:0] top; // top of count sequence
   logic [2:0] events; // overflow, match a, match b

   assign req = '{addr: addr, wdata: wdata, wr: wr, rd: rd};

   ////////////////////////////////////////////////////////////////////////////
   // count pin sampling

   // latch open during the high phase, so the pin is caught half a cycle
   // before the rising-edge flop; this gives the half-cycle in the delay
   always_latch begin
      if (clock) begin
         pin_latch <= external_count_pin;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // tick selection

   // tap pulses when all lower prescaler bits are ones, i.e. once per period
   assign tap[0] = &state.presc[2:0];
   assign tap[1] = &state.presc[5:0];
   assign tap[2] = &state.presc[7:0];
   assign tap[3] = &state.presc[9:0];
   assign psr_active = state.psr;
   // edge detect between flop output and its previous value
   assign ext_rise = state.ext_sync[1] & ~state.ext_prev;
   assign ext_fall = ~state.ext_sync[1] & state.ext_prev;

   // one chooser for each timer, each with its own select field
   function automatic logic pick_tick(input logic [2:0] cs, input logic [3:0] taps,
                                      input logic rise, input logic fall, input logic held);
      logic t;
      t = 1'b0;
      case (cs)
         `STP_CS_STOP: t = 1'b0;
         `STP_CS_DIRECT: t = 1'b1;
         `STP_CS_DIV8: t = taps[0] & ~held;
         `STP_CS_DIV64: t = taps[1] & ~held;
         `STP_CS_DIV256: t = taps[2] & ~held;
         `STP_CS_DIV1024: t = taps[3] & ~held;
         `STP_CS_FALL: t = fall;
         `STP_CS_RISE: t = rise;
         default: t = 1'b0;
      endcase
      return t;
   endfunction

   assign tick0 = pick_tick(state.cs0, tap, ext_rise, ext_fall, psr_active);
   assign tick1 = pick_tick(state.cs1, tap, ext_rise, ext_fall, psr_active);
   assign timer_tick0 = tick0;
   assign timer_tick1 = tick1;
   // capture trigger for timer 1 follows the chosen input
   assign capture_trigger1 = state.capsel ? capture_input_b : capture_input_a;

   ////////////////////////////////////////////////////////////////////////////
   // counter helpers

   assign wr_count = req.wr && (req.addr == `STP_OFS_COUNT);
   assign top = state.top_a ? state.cmp_a : `STP_MAX;
   // interrupt line: any flag that its mask lets through
   assign timer_irq = |(state.flags & state.mask);
   assign rdata = state.rdata;

   ////////////////////////////////////////////////////////////////////////////
   // next state

   always_comb begin
      next_state = state;
      events = 3'h0;
      // prescaler runs every cycle whatever the selects say; only the psr bit clears it and keeps it at zero
      if (state.psr) begin
         next_state.presc = 10'h000;
      end else begin
         next_state.presc = state.presc + 10'h001;
      end
      // two-stage pin path: latch then flop, then previous value for edges
      next_state.ext_sync = {pin_latch, 1'b0};
      next_state.ext_sync[0] = 1'b0;
      next_state.ext_prev = state.ext_sync[1];
      // prescaler reset bit clears itself unless the hold bit keeps it
      if (!state.hold) begin
         next_state.psr = 1'b0;
      end
      // counting only when powered and a source ticks
      if (!state.pwr_off && tick0) begin
         if (!state.block_cmp && state.count == state.cmp_a) begin
            events[`STP_BIT_CMPA] = 1'b1;
         end
         if (!state.block_cmp && state.count == state.cmp_b) begin
            events[`STP_BIT_CMPB] = 1'b1;
         end
         if (state.count == top) begin
            next_state.count = `STP_BOTTOM;
            events[`STP_BIT_OVF] = 1'b1;
         end else begin
            next_state.count = state.count + 8'h01;
         end
         next_state.block_cmp = 1'b0;
      end
      // register reads answer one cycle later
      next_state.rdata = 8'h00;
      if (req.rd) begin
         case (req.addr)
            `STP_OFS_SYNC_CTRL: next_state.rdata = {state.hold, state.capsel, 5'h00, state.psr};
            `STP_OFS_CLK_SEL: next_state.rdata = {1'b0, state.cs1, 1'b0, state.cs0};
            `STP_OFS_COUNT: next_state.rdata = state.count;
            `STP_OFS_CMP_A: next_state.rdata = state.cmp_a;
            `STP_OFS_CMP_B: next_state.rdata = state.cmp_b;
            `STP_OFS_FLAGS: next_state.rdata = {5'h00, state.flags};
            `STP_OFS_MASK: next_state.rdata = {5'h00, state.mask};
            `STP_OFS_CTRL: next_state.rdata = {6'h00, state.top_a, state.pwr_off};
            default: next_state.rdata = 8'h00; // unmapped reads as zero
         endcase
      end
      // register writes
      if (req.wr) begin
         case (req.addr)
            `STP_OFS_SYNC_CTRL: begin
               next_state.hold = req.wdata[`STP_BIT_HOLD];
               next_state.capsel = req.wdata[`STP_BIT_CAPSEL];
               // with hold set the written value stands; clearing a hold that was set clears it
               if (req.wdata[`STP_BIT_HOLD]) begin
                  next_state.psr = req.wdata[`STP_BIT_PSR];
               end else begin
                  // a one resets the prescaler for a single cycle only if hold was not already set
                  next_state.psr = req.wdata[`STP_BIT_PSR] & ~state.hold;
               end
            end
            `STP_OFS_CLK_SEL: begin
               next_state.cs0 = req.wdata[`STP_CS0_LSB +: 3];
               next_state.cs1 = req.wdata[`STP_CS1_LSB +: 3];
            end
            `STP_OFS_COUNT: begin
               // processor write wins over counting and masks the next match
               next_state.count = req.wdata;
               next_state.block_cmp = 1'b1;
            end
            `STP_OFS_CMP_A: next_state.cmp_a = req.wdata;
            `STP_OFS_CMP_B: next_state.cmp_b = req.wdata;
            `STP_OFS_MASK: next_state.mask = req.wdata[2:0];
            `STP_OFS_CTRL: begin
               next_state.pwr_off = req.wdata[`STP_BIT_PWR_OFF];
               next_state.top_a = req.wdata[`STP_BIT_TOP_A];
            end
            default: begin
               // unmapped write is ignored
            end
         endcase
      end
      // flags: write one to clear, hardware set wins over the clear
      if (req.wr && req.addr == `STP_OFS_FLAGS) begin
         next_state.flags = (state.flags & ~req.wdata[2:0]) | events;
      end else begin
         next_state.flags = state.flags | events;
      end
      if (wr_count && tick0 && !state.pwr_off) begin
         next_state.count = req.wdata;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // state register

   // one register for the whole block; everything resets to constants
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         state <= '0;
         // only bit 0 of the control reset value is copied here; top_a keeps the zero from the clear
         state.pwr_off <= 1'(`STP_RST_CTRL);
      end else begin
         state <= next_state;
      end
   end

endmodule

/* File: verif/stp_properties.sv */
// port assertions of the shared timer prescaler
`timescale 1ns/1ps
module stp_properties (
   input wire logic clock,
   input wire logic rst_n,
   input wire logic [3:0] addr,
   input wire logic [7:0] wdata,
   input wire logic wr,
   input wire logic external_count_pin,
   input wire logic capture_input_a,
   input wire logic capture_input_b,
   input wire logic timer_tick1,
   input wire logic capture_trigger1,
   input wire logic timer_irq
);
   logic [2:0] cs1, mask; // shadows of timer 1 select and irq mask
   logic capsel, held; // shadows of capture choice and held prescaler reset
   default clocking @(posedge clock); endclocking
   default disable iff (!rst_n);
   ////////////////////////////////////////////////////////////////
   // shadows follow writes on the same edge as the block does
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         {cs1, mask, capsel, held} <= 8'h00;
      end else if (wr && addr == 4'h0) begin
         {held, capsel} <= {wdata[7] & wdata[0], wdata[6]};
      end else if (wr && addr == 4'h1) begin
         cs1 <= wdata[6:4];
      end else if (wr && addr == 4'h6) begin
         mask <= wdata[2:0];
      end
   end
   ////////////////////////////////////////////////////////////////
   // the /8 tap: seven quiet cycles, then the next tick
   sequence s_gap; !timer_tick1 [*7] ##1 timer_tick1; endsequence
   property p_cap; capture_trigger1 == (capsel ? capture_input_b : capture_input_a); endproperty
   a_cap: assert property (p_cap) else $error("capture source wrong");
   property p_direct; cs1 == 3'h1 |-> timer_tick1; endproperty
   a_direct: assert property (p_direct) else $error("direct tick missing");
   property p_stop; cs1 == 3'h0 |-> !timer_tick1; endproperty
   a_stop: assert property (p_stop) else $error("tick while stopped");
   // wr aborts: a new select changes the tick source and a prescaler reset restarts the taps
   property p_div8; disable iff (!rst_n || wr) cs1 == 3'h2 && timer_tick1 |=> s_gap; endproperty
   a_div8: assert property (p_div8) else $error("tap spacing wrong");
   property p_ext; ($rose(external_count_pin) && cs1 == 3'h7) ||
      ($fell(external_count_pin) && cs1 == 3'h6) |-> ##[1:3] timer_tick1; endproperty
   a_ext: assert property (p_ext) else $error("pin edge not counted");
   property p_once; timer_tick1 && cs1 inside {3'h6, 3'h7} |=> !timer_tick1; endproperty
   a_once: assert property (p_once) else $error("edge gave two ticks");
   property p_hold; held && cs1 inside {[3'h2:3'h5]} |-> !timer_tick1; endproperty
   a_hold: assert property (p_hold) else $error("tick while held");
   property p_irq; $past(mask) == 3'h0 && mask == 3'h0 |-> !timer_irq; endproperty
   a_irq: assert property (p_irq) else $error("irq while masked");
endmodule
bind stp_timer_prescaler stp_properties i_stp_properties (.*);

/* File: verif/stp_pin_source.sv */
// external clock source on the count pin
`timescale 1ns/1ps
module stp_pin_source #(parameter int HALF_NS = 20) (
   input wire logic run,
   output logic pin
);
   // holds its level while stopped, so selects change on a stable pin;
   // 40 ns period stays under the system rate divided by 2.5; the 3 ns
   // offset keeps every pin edge away from a rising clock edge
   initial begin
      pin = 1'b0;
      #3;
      forever begin
         #(HALF_NS);
         if (run) pin = ~pin;
      end
   end
endmodule

/* File: verif/tb_top.sv */
// self-checking bench of the shared timer prescaler
`timescale 1ns/1ps
module tb_top;
   logic clock = 0, rst_n = 0, wr = 0, rd = 0, cap_a = 0, cap_b = 0, pin_run = 0;
   logic [3:0] addr = 4'h0;
   logic [7:0] wdata = 8'h00, rdata, rv;
   logic pin, tick0, tick1, trig, irq;
   int bad_count = 0, cmp_count = 0, rises = 0, falls = 0;
   always #5 clock = ~clock;
   // edge counts of the pin are the model of the external ticks
   always @(posedge pin) rises++;
   always @(negedge pin) falls++;
   stp_timer_prescaler i_stp_timer_prescaler (.clock(clock), .rst_n(rst_n), .addr(addr),
      .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .external_count_pin(pin),
      .capture_input_a(cap_a), .capture_input_b(cap_b), .timer_tick0(tick0),
      .timer_tick1(tick1), .capture_trigger1(trig), .timer_irq(irq));
   stp_pin_source i_stp_pin_source (.run(pin_run), .pin(pin));
   ////////////////////////////////////////////////////////////////
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         bad_count++;
         $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task automatic put(input logic [3:0] a, input logic [7:0] d);
      @(posedge clock);
      wr <= 1'b1;
      addr <= a;
      wdata <= d;
      @(posedge clock);
      wr <= 1'b0;
   endtask
   // read data stands only in the cycle after the strobe
   task automatic get(input logic [3:0] a);
      @(posedge clock);
      rd <= 1'b1;
      addr <= a;
      @(posedge clock);
      rd <= 1'b0;
      #1 rv = rdata;
   endtask
   task automatic getc(input logic [3:0] a, input logic [7:0] e);
      get(a);
      chk(rv, e);
   endtask
   task automatic summarize();
      $display("compares %0d mismatches %0d", cmp_count, bad_count);
      if (bad_count == 0 && cmp_count > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask
   ////////////////////////////////////////////////////////////////
   initial begin
      int n, k, e;
      int dv[8] = '{1, 1, 8, 64, 256, 1024, 1, 1};
      void'($urandom(32'hb0a0c528));
      repeat (6) @(posedge clock);
      rst_n <= 1'b1;
      getc(4'h0, 8'h00);
      getc(4'h7, 8'h01);
      getc(4'h9, 8'h00);
      // random values survive in compare and mask registers
      for (int a = 3; a < 7; a++) begin
         n = $urandom;
         if (a != 5) put(4'(a), 8'(n));
         if (a != 5) getc(4'(a), 8'(a == 6 ? n & 7 : n));
      end
      repeat (8) begin
         n = $urandom;
         put(4'h0, {1'b0, n[0], 6'h00});
         cap_a <= n[1];
         cap_b <= n[2];
         @(negedge clock);
         chk(trig, n[0] ? n[2] : n[1]);
      end
      // every select code of timer 1 over a 2048 cycle window
      for (int c = 0; c < 8; c++) begin
         put(4'h1, 8'(c << 4));
         {rises, falls, k} = 0;
         for (int i = 0; i < 2048; i++) begin
            @(negedge clock);
            pin_run <= c > 5 && i < 300;
            if (tick1 === 1'b1) k++;
         end
         e = c == 0 ? 0 : c == 6 ? falls : c == 7 ? rises : 2048 / dv[c];
         chk(c > 1 && c < 6 && k >= e - 1 && k <= e + 1 ? e : k, e);
      end
      // timer 0 wraps past the maximum, flags it and raises the irq
      put(4'h7, 8'h00);
      put(4'h2, 8'hfe);
      put(4'h1, 8'h01);
      @(negedge clock);
      chk(tick0, 1'b1);
      repeat (3) @(posedge clock);
      put(4'h1, 8'h00);
      get(4'h5);
      chk(rv[0], 1'b1);
      put(4'h6, 8'h01);
      repeat (2) @(negedge clock);
      chk(irq, 1'b1);
      put(4'h5, 8'h07);
      repeat (2) @(negedge clock);
      chk(irq, 1'b0);
      get(4'h2);
      n = rv;
      repeat (9) @(posedge clock);
      getc(4'h2, 8'(n));
      // hold mode keeps the prescaler in reset until released
      put(4'h1, 8'h20);
      put(4'h0, 8'h81);
      getc(4'h0, 8'h81);
      k = 0;
      repeat (64) @(negedge clock) if (tick1 === 1'b1) k++;
      chk(k, 0);
      put(4'h0, 8'h00);
      getc(4'h0, 8'h00);
      put(4'h0, 8'h01);
      getc(4'h0, 8'h00);
      summarize();
   end
   // the tests need about 17k cycles
   initial begin
      #400000;
      bad_count++;
      summarize();
   end
endmodule
